// *** core/dcr_pkg.sv ***
// Package for the DAC control register and readback block.
// Assumes one system clock domain plus the serial link clock domain.
package dcr_pkg;
   localparam int FRAME_BITS        = 24;
   localparam int CMD_LSB           = 16;
   localparam int CMD_MSB           = 19;
   localparam int FIX_BIT           = 20;
   localparam logic [3:0] CMD_WRITE_CTRL = 4'h4;
   localparam logic [3:0] CMD_READ_CTRL  = 4'hc;
   localparam logic [3:0] CMD_DATA_RESET = 4'h7;
   localparam logic [3:0] CMD_FULL_RESET = 4'hf;
   localparam int SHORT_BIT         = 12;
   localparam int BROWN_BIT         = 11;
   localparam int CV_LSB            = 9;
   localparam int OVR_BIT           = 8;
   localparam int B2C_BIT           = 7;
   localparam int ETS_BIT           = 6;
   localparam int IRO_BIT           = 5;
   localparam int PV_LSB            = 3;
   localparam int RA_LSB            = 0;
   localparam logic [10:0] CFG_RESET = 11'h000;
   localparam logic [1:0] SCALE_ZERO = 2'h0;
   localparam logic [1:0] SCALE_MID  = 2'h1;
   localparam logic [1:0] SCALE_FULL = 2'h2;

   typedef enum logic [2:0] {
      DCR_PM10 = 3'b000, DCR_U10 = 3'b001, DCR_PM5 = 3'b010, DCR_U5 = 3'b011,
      DCR_M25P75 = 3'b100, DCR_PM3 = 3'b101, DCR_U16 = 3'b110, DCR_U20 = 3'b111
   } dcr_span_t;

   typedef struct packed {
      logic [1:0] clear_value_sel;
      logic       span_extend_en;
      logic       bipolar_coding_sel;
      logic       thermal_supply_cut_en;
      logic       int_vref_on;
      logic [1:0] powerup_value_sel;
      logic [2:0] output_span_sel;
   } dcr_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] cmd;
      logic [15:0] data;
   } dcr_frame_t;

   // 00 zero, 01 mid, 10/11 full
   function automatic logic [1:0] dcr_scale(input logic [1:0] sel);
      dcr_scale = (sel == 2'h0) ? SCALE_ZERO : (sel == 2'h1) ? SCALE_MID : SCALE_FULL;
   endfunction
endpackage

// *** core/dcr_sync.sv ***
// Three-stage synchroniser with agreement filter.
// Assumes d is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module dcr_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q  <= 1'b0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/dcr_top.sv ***
// DAC control register, status flags and serial readback.
// Assumes host drives sclk, sync_n, sdi; sclk may stop between frames.
`timescale 1ns/1ps
`default_nettype none
module dcr_top
   import dcr_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                sclk,
   input  wire logic                sync_n,
   input  wire logic                sdi,
   output logic                     serial_out_pin,
   output logic                     serial_out_oe_n,
   input  wire logic                clear_n,
   input  wire logic                short_detect,
   input  wire logic                brownout_detect,
   input  wire logic                overtemp,
   output dcr_pkg::dcr_cfg_t        cfg,
   output logic                     span_extend,
   output logic                     coding_invert_msb,
   output logic                     digital_supply_on,
   output logic                     int_vref_en,
   output logic [2:0]               span_code,
   output logic [1:0]               output_force_scale,
   output logic                     output_force,
   output logic                     full_reset_req
);
   import dcr_pkg::*;

   // ---------------- Link clock domain ----------------
   logic [23:0] rx_shift;
   logic [4:0]  rx_count;
   logic [23:0] tx_shift;
   logic        frame_full;
   logic [23:0] frame_word;
   logic        tx_armed;
   logic [23:0] tx_word;
   logic        tx_armed_seen;
   logic [23:0] tx_word_link;

   // Frame bits are captured on rising sclk while sync_n is low
   always_ff @(posedge sclk or posedge sync_n) begin
      if (sync_n) begin
         rx_count   <= 5'h00;
         frame_full <= 1'b0;
      end else begin
         rx_shift <= {rx_shift[22:0], sdi};
         if (rx_count != 5'(FRAME_BITS)) begin
            rx_count <= rx_count + 5'h01;
         end
         if (rx_count == 5'(FRAME_BITS - 1)) begin
            frame_word <= {rx_shift[22:0], sdi};
            frame_full <= 1'b1;
         end
      end
   end

   // Armed level and response word settle in sys_clk while sclk is stopped
   // between frames, so the first falling edge may take them directly

   // First falling edge of a frame loads the response, then shifts MSB first
   always_ff @(negedge sclk or posedge sync_n) begin
      if (sync_n) begin
         tx_armed_seen <= 1'b0;
         tx_shift      <= 24'h000000;
      end else if (!tx_armed_seen) begin
         tx_armed_seen <= 1'b1;
         tx_shift      <= tx_armed ? {tx_word_link[22:0], 1'b0} : 24'h000000;
      end else begin
         tx_shift <= {tx_shift[22:0], 1'b0};
      end
   end
   assign tx_word_link = tx_word;

   // First bit (23) is presented before the first edge
   assign serial_out_pin  = tx_armed_seen ? tx_shift[23]
                                          : (tx_armed & tx_word[23]);
   assign serial_out_oe_n = sync_n;

   // ---------------- System clock domain ----------------
   logic        tgl_s1;
   logic        tgl_s2;
   logic        tgl_s3;
   logic        frame_done;
   dcr_frame_t  rx_frame;
   logic        short_flag;
   logic        brownout_flag;
   logic        short_sync;
   logic        brown_sync;
   logic        temp_sync;
   logic        clear_sync;
   logic        clear_prev;
   logic        write_ctrl;
   logic        data_reset;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
      end else begin
         tgl_s1 <= frame_full;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
      end
   end
   // Rising edge of the full-frame level; the word stays put until the next frame
   assign frame_done = tgl_s2 & ~tgl_s3;

   always_comb begin
      rx_frame.valid = frame_done;
      rx_frame.cmd   = frame_word[CMD_MSB:CMD_LSB];
      rx_frame.data  = frame_word[15:0];
   end

   assign write_ctrl = rx_frame.valid && (rx_frame.cmd == CMD_WRITE_CTRL);
   assign data_reset = rx_frame.valid && (rx_frame.cmd == CMD_DATA_RESET);

   // Stored configuration, held until the next write or reset
   always_ff @(posedge sys_clk) begin
      if (rst || (rx_frame.valid && rx_frame.cmd == CMD_FULL_RESET)) begin
         cfg <= dcr_cfg_t'(CFG_RESET);
      end else if (write_ctrl) begin
         cfg <= dcr_cfg_t'(rx_frame.data[10:0]);
      end
   end

   assign full_reset_req = rx_frame.valid && (rx_frame.cmd == CMD_FULL_RESET);

   dcr_sync u_sync_short (
      .clk (sys_clk),
      .rst (rst),
      .d   (short_detect),
      .q   (short_sync)
   );
   dcr_sync u_sync_brown (
      .clk (sys_clk),
      .rst (rst),
      .d   (brownout_detect),
      .q   (brown_sync)
   );
   dcr_sync u_sync_temp (
      .clk (sys_clk),
      .rst (rst),
      .d   (overtemp),
      .q   (temp_sync)
   );
   dcr_sync u_sync_clear (
      .clk (sys_clk),
      .rst (rst),
      .d   (clear_n),
      .q   (clear_sync)
   );

   // Sticky flags: detection wins over a clearing write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         short_flag <= 1'b0;
      end else if (short_sync) begin
         short_flag <= 1'b1;
      end else if (write_ctrl) begin
         short_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         brownout_flag <= 1'b0;
      end else if (brown_sync) begin
         brownout_flag <= 1'b1;
      end else if (write_ctrl) begin
         brownout_flag <= 1'b0;
      end
   end

   // Readback armed for the frame following a 1100 request
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_armed <= 1'b0;
         tx_word  <= 24'h000000;
      end else if (rx_frame.valid) begin
         tx_armed <= (rx_frame.cmd == CMD_READ_CTRL);
         tx_word  <= {3'h0, 1'b0, CMD_READ_CTRL, 3'h0,
                      short_flag, brownout_flag, cfg};
      end
   end

   // Output forcing from clear pin edge or software data reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clear_prev         <= 1'b0;
         output_force       <= 1'b0;
         output_force_scale <= SCALE_ZERO;
      end else begin
         clear_prev   <= clear_sync;
         output_force <= 1'b0;
         if (clear_prev && !clear_sync) begin
            output_force       <= 1'b1;
            output_force_scale <= dcr_scale(cfg.clear_value_sel);
         end else if (data_reset) begin
            output_force       <= 1'b1;
            output_force_scale <= dcr_scale(cfg.powerup_value_sel);
         end
      end
   end

   // Analog-facing controls from stored fields
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         span_extend       <= 1'b0;
         coding_invert_msb <= 1'b0;
         digital_supply_on <= 1'b1;
         int_vref_en       <= 1'b0;
         span_code         <= 3'h0;
      end else begin
         span_extend       <= cfg.span_extend_en;
         coding_invert_msb <= cfg.bipolar_coding_sel;
         digital_supply_on <= !(cfg.thermal_supply_cut_en && temp_sync);
         int_vref_en       <= cfg.int_vref_on;
         span_code         <= dcr_span_t'(cfg.output_span_sel);
      end
   end
endmodule
`default_nettype wire

// *** dv/dcr_asserts.sv ***
// Port checks for the control register block.
// Assumes binding to dcr_top; sync_n frames are spaced by the host.
`timescale 1ns/1ps
`default_nettype none
module dcr_asserts
   import dcr_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              sync_n,
   input wire logic              serial_out_oe_n,
   input wire logic              clear_n,
   input wire logic              overtemp,
   input wire dcr_pkg::dcr_cfg_t cfg,
   input wire logic              span_extend,
   input wire logic              coding_invert_msb,
   input wire logic              digital_supply_on,
   input wire logic              int_vref_en,
   input wire logic [2:0]        span_code,
   input wire logic              output_force,
   input wire logic              full_reset_req
);
   import dcr_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_oe_tracks_frame: assert property (serial_out_oe_n == sync_n)
      else $error("oe differs from frame select");
   a_span_copy: assert property (span_code == $past(cfg.output_span_sel))
      else $error("span code lags cfg");
   a_extend_copy: assert property (span_extend == $past(cfg.span_extend_en))
      else $error("span extend lags cfg");
   a_coding_copy: assert property (coding_invert_msb == $past(cfg.bipolar_coding_sel))
      else $error("coding lags cfg");
   a_vref_copy: assert property (int_vref_en == $past(cfg.int_vref_on))
      else $error("vref lags cfg");
   a_supply_kept: assert property ($past(!cfg.thermal_supply_cut_en) |-> digital_supply_on)
      else $error("supply cut while disabled");
   a_supply_cut: assert property ((cfg.thermal_supply_cut_en && overtemp) [*8] |-> !digital_supply_on)
      else $error("supply kept when hot");
   a_force_pulse: assert property (output_force |=> !output_force)
      else $error("force longer than a cycle");
   a_clear_force: assert property ($fell(clear_n) |-> ##[1:10] output_force)
      else $error("no force after clear");
   a_full_reset_cfg: assert property (full_reset_req |-> ##[1:2] cfg == CFG_RESET)
      else $error("cfg kept after full reset");
endmodule
bind dcr_top dcr_asserts dcr_asserts_inst (.sys_clk, .rst, .sync_n, .serial_out_oe_n,
   .clear_n, .overtemp, .cfg, .span_extend, .coding_invert_msb, .digital_supply_on,
   .int_vref_en, .span_code, .output_force, .full_reset_req);
`default_nettype wire

// *** dv/dcr_host_model.sv ***
// Host serial port: 24-bit frames, sclk idle low, 125 ns period.
// Assumes the device shifts out on falling sclk.
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
   output logic        sclk,
   output logic        sync_n,
   output logic        sdi,
   input  wire logic   serial_out_pin,
   input  wire logic   serial_out_oe_n,
   output logic [23:0] rx_word,
   output logic        rx_strobe
);
   initial begin
      {sclk, sync_n, sdi, rx_strobe} = 4'h0;
      rx_word = 24'h0;
      // Rising select clears the link-side frame state
      #1 sync_n = 1'b1;
   end
   // One frame MSB first, then a gap well over 250 ns
   task automatic send(input logic [23:0] w);
      #7 sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = w[i];
         #62.5;
         rx_word[i] = serial_out_oe_n ? 1'bx : serial_out_pin;
         sclk = 1'b1;
         #62.5;
         sclk = 1'b0;
      end
      #30 sync_n = 1'b1;
      // Released line must not look like held data
      sdi = ~sdi;
      rx_strobe = 1'b1;
      #1 rx_strobe = 1'b0;
      #400;
   endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the control register block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dcr_pkg::*;
   logic        sys_clk, rst, sclk, sync_n, sdi, serial_out_pin, serial_out_oe_n;
   logic        clear_n, short_detect, brownout_detect, overtemp, rx_strobe;
   logic        span_extend, coding_invert_msb, digital_supply_on, int_vref_en;
   logic        output_force, full_reset_req, sc_e, bo_e;
   logic [2:0]  span_code;
   logic [1:0]  output_force_scale, f_scale;
   logic [23:0] rx_word, last_resp;
   logic [23:0] exp_q[$];
   dcr_cfg_t    cfg, cm, c;
   int          bad_count, cmp_count, cycles, n_force, base, seed;
   dcr_top dcr_top_inst (.sys_clk, .rst, .sclk, .sync_n, .sdi, .serial_out_pin,
      .serial_out_oe_n, .clear_n, .short_detect, .brownout_detect, .overtemp, .cfg,
      .span_extend, .coding_invert_msb, .digital_supply_on, .int_vref_en, .span_code,
      .output_force_scale, .output_force, .full_reset_req);
   dcr_host_model dcr_host_model_inst (.sclk, .sync_n, .sdi, .serial_out_pin,
      .serial_out_oe_n, .rx_word, .rx_strobe);
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Each frame returns what the previous one asked for
   task automatic frame(input logic [3:0] cmd, input logic [15:0] d);
      exp_q.push_back(last_resp);
      last_resp = (cmd == CMD_READ_CTRL) ? {4'h0, cmd, 3'h0, sc_e, bo_e, cm} : 24'h0;
      if (cmd == CMD_WRITE_CTRL) begin
         cm = d[10:0];
         {sc_e, bo_e} = 2'b00;
      end
      if (cmd == CMD_FULL_RESET) cm = CFG_RESET;
      dcr_host_model_inst.send({4'h0, cmd, d});
   endtask
   always @(posedge rx_strobe) chk(rx_word, exp_q.pop_front());
   always @(negedge sys_clk) begin
      cycles++;
      if (output_force) begin
         n_force++;
         f_scale = output_force_scale;
      end
      if (cycles == 10000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      seed = 32'h1196;
      {rst, clear_n, short_detect, brownout_detect, overtemp} = 5'h18;
      {sc_e, bo_e, last_resp, cm} = '0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         frame(CMD_FULL_RESET, 16'h0);
         c = 11'($random(seed));
         c.output_span_sel = 3'(i);
         frame(CMD_WRITE_CTRL, {5'($random(seed)), c});
         frame(CMD_READ_CTRL, 16'($random(seed)));
         chk({span_extend, coding_invert_msb, int_vref_en, span_code, cfg},
             {c[8], c[7], c[5], c[2:0], c});
      end
      @(negedge sys_clk) short_detect = 1'b1;
      repeat (10) @(negedge sys_clk);
      sc_e = 1'b1;
      frame(CMD_READ_CTRL, 16'hffff);
      @(negedge sys_clk) {short_detect, brownout_detect} = 2'b01;
      repeat (10) @(negedge sys_clk);
      bo_e = 1'b1;
      frame(CMD_READ_CTRL, 16'h0);
      @(negedge sys_clk) brownout_detect = 1'b0;
      repeat (10) @(negedge sys_clk);
      cm.thermal_supply_cut_en = 1'b1;
      frame(CMD_WRITE_CTRL, {5'h0, cm});
      frame(CMD_READ_CTRL, 16'h0);
      @(negedge sys_clk) overtemp = 1'b1;
      repeat (12) @(negedge sys_clk);
      chk(digital_supply_on, 1'b0);
      overtemp = 1'b0;
      repeat (12) @(negedge sys_clk);
      chk(digital_supply_on, 1'b1);
      base = n_force;
      for (int v = 0; v < 4; v++) begin
         c = cm;
         c.clear_value_sel = 2'(v);
         c.powerup_value_sel = 2'(3 - v);
         frame(CMD_WRITE_CTRL, {5'h0, c});
         @(negedge sys_clk) clear_n = 1'b0;
         repeat (12) @(negedge sys_clk);
         clear_n = 1'b1;
         chk(f_scale, v[1] ? 2'h2 : 2'(v));
         frame(CMD_DATA_RESET, 16'h0);
         repeat (8) @(negedge sys_clk);
         chk(f_scale, v < 2 ? 2'h2 : 2'(3 - v));
         chk(24'(n_force - base), 24'(2 * v + 2));
      end
      frame(4'h0, 16'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
